//--- kbm_mailbox.sv
// keyboard controller host mailbox: data buffers, status byte, host
// interrupts, keyboard/aux line drive and the fast gate/reset register.
// assumes single-cycle host and cpu strobes, synchronous to clk_i, and a
// configuration register supplied from outside.
`timescale 1ns/1ns
`default_nettype none
`include "kbm_map.svh"

// What this block does
// R1: cpu data write loads host read buffer, sets output full, raises keyboard irq
// R2: cpu data read returns last host byte and clears input full
// R3: status byte: output full D0, input full D1, command flag D3, user bits elsewhere
// R4: cpu writes user bits freely; host sees them on status reads
// R5: status is read-only to host, readable and writable by cpu
// R6: each host data or command write copies address bit two into the command flag
// R7: host write sets input full and cpu irq; cpu read clears both
// R8: host read of output buffer clears output full
// R9: controller runs from a 10 MHz clock derived from a reference
// R10: reset must stay active at least 24 reference periods to count; the block resets asynchronously on any sys_rst_i pulse
// R11: only hardware reset; drives four lines low, clears status and both data buffers
// R12: fast gate register answers host only while config bit 2 is set
// R13: fast gate reads 24h pattern on fixed bits, ignores writes there
// R14: fast gate bit 1 drives the alternate address-20 gate level
// R15: writing 1 to bit 0 pulses alternate reset low 1 us after 500 ns
// R16: bit 0 clears on reset; must return to 0 before next pulse
// R17: port 60h is data, 64h is command/status
// R18: with flags enabled keyboard irq follows output full gated by port bit
// R19: address-20 mask is OR of controller gate bit and alternate gate
// R20: delay and pulse width counted on controller clock, rounded up
module kbm_mailbox
(
    input  wire logic                   clk_i,                // controller clock
    input  wire logic                   sys_rst_i,            // host bus reset, active high
    // host i/o side
    input  wire logic [`KBM_ADDR_W-1:0] host_addr_i,          // i/o address
    input  wire logic                   host_rd_i,            // read strobe
    input  wire logic                   host_wr_i,            // write strobe
    input  wire logic [7:0]             host_wdata_i,         // write data
    output logic [7:0]                  host_rdata_o,         // read data, next cycle
    output logic                        host_claim_o,         // address decoded here
    input  wire logic [7:0]             kbd_reset_gate_cfg_i, // configuration byte
    output logic                        kbd_host_irq_o,       // keyboard host irq
    output logic                        aux_host_irq_o,       // aux host irq
    // embedded cpu side
    input  wire logic                   cpu_dbb_wr_i,         // write data bus buffer
    input  wire logic                   cpu_dbb_rd_i,         // read data bus buffer
    input  wire logic                   cpu_sts_wr_i,         // write status byte
    input  wire logic                   cpu_sts_rd_i,         // read status byte
    input  wire logic [7:0]             cpu_wdata_i,          // cpu write data
    output logic [7:0]                  cpu_rdata_o,          // cpu read data, next cycle
    output logic                        cpu_cmd_flag_o,       // last host byte was command
    input  wire logic                   cpu_en_flags_i,       // enable flags mode
    input  wire logic                   cpu_ibf_irq_en_i,     // input full irq enable
    output logic                        input_full_irq_n_o,   // input full irq, low active
    input  wire logic                   port_bit_irq_kbd_i,   // keyboard irq port bit
    input  wire logic                   port_bit_irq_aux_i,   // aux irq port bit
    input  wire logic                   port_bit_addr_gate_i, // controller gate bit
    input  wire logic [3:0]             cpu_line_drive_i,     // 1 pulls a line low
    output logic [3:0]                  cpu_line_state_o,     // sampled line levels
    // keyboard and aux open-drain lines
    input  wire logic                   kbd_clock_line_i,     // keyboard clock level
    output logic                        kbd_clock_line_o,     // keyboard clock out
    output logic                        kbd_clock_line_oe_o,  // keyboard clock drive
    input  wire logic                   kbd_data_line_i,      // keyboard data level
    output logic                        kbd_data_line_o,      // keyboard data out
    output logic                        kbd_data_line_oe_o,   // keyboard data drive
    input  wire logic                   aux_clock_line_i,     // aux clock level
    output logic                        aux_clock_line_o,     // aux clock out
    output logic                        aux_clock_line_oe_o,  // aux clock drive
    input  wire logic                   aux_data_line_i,      // aux data level
    output logic                        aux_data_line_o,      // aux data out
    output logic                        aux_data_line_oe_o,   // aux data drive
    // system control
    output logic                        alt_addr20_gate_o,    // alternate address-20 gate
    output logic                        alt_cpu_reset_n_o,    // alternate cpu reset, low
    output logic                        cpu_addr20_mask_n_o   // address-20 mask to cpu
);
    import kbm_pkg::*;

    // ----
    // helpers
    // ----

    // exact port decode, shared by every host access
    function automatic logic host_hit(input logic [`KBM_ADDR_W-1:0] addr,
                                      input logic [`KBM_ADDR_W-1:0] port);
        host_hit = (addr == port);
    endfunction

    // assemble the status byte from flags and user bits
    function automatic logic [7:0] status_byte(input kbm_state_t s);
        logic [7:0] b;
        b = s.user_bits & `KBM_ST_UD_MASK;         // R3
        b[`KBM_ST_OBF] = s.output_buffer_full;                    // R3
        b[`KBM_ST_IBF] = s.input_buffer_full;                    // R3
        b[`KBM_ST_CMD] = s.cmd_flag;               // R3
        status_byte = b;
    endfunction

    // fast gate read value: fixed bits plus the two live bits
    function automatic logic [7:0] fast_gate_byte(input kbm_state_t s);
        logic [7:0] b;
        b = `KBM_FG_FIXED;                         // R13
        b[`KBM_FG_GATE_BIT] = s.alt_gate;
        b[`KBM_FG_RST_BIT]  = s.alt_rst_bit;
        fast_gate_byte = b;
    endfunction

    // ----
    // state and decode
    // ----
    kbm_state_t st_reg;
    kbm_state_t st_next;

    logic hit_data;
    logic hit_cmd;
    logic hit_gate;
    logic gate_en;
    logic host_buf_wr;
    logic host_data_rd;
    logic host_sts_rd;
    logic gate_wr;
    logic gate_rd;
    logic alt_fire;
    logic alt_busy;

    // port decode; 60h and 64h differ only in address bit two
    assign hit_data     = host_hit(host_addr_i, `KBM_ADDR_DATA);        // R17
    assign hit_cmd      = host_hit(host_addr_i, `KBM_ADDR_CMD);         // R17
    assign hit_gate     = host_hit(host_addr_i, `KBM_ADDR_FAST_GATE);
    assign gate_en      = kbd_reset_gate_cfg_i[`KBM_CFG_FG_EN_BIT];     // R12
    assign host_buf_wr  = host_wr_i & (hit_data | hit_cmd);
    assign host_data_rd = host_rd_i & hit_data;                         // R17
    assign host_sts_rd  = host_rd_i & hit_cmd;                          // R17
    assign gate_wr      = host_wr_i & hit_gate & gate_en;               // R12
    assign gate_rd      = host_rd_i & hit_gate & gate_en;               // R12

    // a fresh pulse needs bit 0 to have been written back to zero first
    assign alt_fire = gate_wr & host_wdata_i[`KBM_FG_RST_BIT] & ~st_reg.alt_rst_bit; // R16

    // claim is combinational so the bus sees it in the request cycle
    assign host_claim_o = hit_data | hit_cmd | (hit_gate & gate_en);    // R12

    // ----
    // next state
    // ----
    always_comb
    begin
        st_next = st_reg;

        // cpu to host: clear on host read first, so a same-cycle cpu write wins
        if (host_data_rd)
        begin
            st_next.output_buffer_full = 1'b0;                    // R8
        end
        if (cpu_dbb_wr_i)
        begin
            st_next.out_buf = cpu_wdata_i;         // R1
            st_next.output_buffer_full     = 1'b1;                // R1
        end

        // host to cpu: cpu read clears, a same-cycle host write wins
        if (cpu_dbb_rd_i)
        begin
            st_next.input_buffer_full = 1'b0;                    // R2 R7
        end
        if (host_buf_wr)
        begin
            st_next.in_buf   = host_wdata_i;
            st_next.input_buffer_full      = 1'b1;                                   // R7
            st_next.cmd_flag = host_addr_i[`KBM_ADDR_BIT_TWO];         // R6
        end

        // only the user bits are cpu writable; hardware owns the flags
        if (cpu_sts_wr_i)
        begin
            st_next.user_bits = cpu_wdata_i & `KBM_ST_UD_MASK;         // R4 R5
        end

        // cpu read port; the data read returns command or data alike
        if (cpu_dbb_rd_i)
        begin
            st_next.cpu_rdata = st_reg.in_buf;     // R2
        end
        else if (cpu_sts_rd_i)
        begin
            st_next.cpu_rdata = status_byte(st_reg);                   // R5
        end

        // host read port; status has no host write path at all
        if (host_data_rd)
        begin
            st_next.host_rdata = st_reg.out_buf;   // R17
        end
        else if (host_sts_rd)
        begin
            st_next.host_rdata = status_byte(st_reg);                  // R4 R5
        end
        else if (gate_rd)
        begin
            st_next.host_rdata = fast_gate_byte(st_reg);               // R13
        end

        // fast gate register; fixed positions of the write are dropped
        if (gate_wr)
        begin
            st_next.alt_gate    = host_wdata_i[`KBM_FG_GATE_BIT];      // R14
            st_next.alt_rst_bit = host_wdata_i[`KBM_FG_RST_BIT];       // R16
        end

        // line drive follows the cpu port bits once out of reset
        st_next.line_drive = cpu_line_drive_i;
        st_next.line_seen  = {aux_data_line_i, aux_clock_line_i,
                              kbd_data_line_i, kbd_clock_line_i};
    end

    // ----
    // state register
    // ----
    // the data buffers keep their reset value only for a defined start;
    // software must not rely on their content after reset
    always_ff @(posedge clk_i or posedge sys_rst_i) // R9
    begin
        if (sys_rst_i)                             // R10 R11
        begin
            st_reg.out_buf     <= 8'h00;
            st_reg.in_buf      <= 8'h00;
            st_reg.output_buffer_full         <= 1'b0;            // R11
            st_reg.input_buffer_full         <= 1'b0;            // R11
            st_reg.cmd_flag    <= 1'b0;            // R11
            st_reg.user_bits   <= `KBM_ST_RESET;   // R11
            st_reg.alt_gate    <= 1'b0;
            st_reg.alt_rst_bit <= 1'b0;            // R16
            st_reg.line_drive  <= `KBM_LINE_RESET; // R11
            st_reg.line_seen   <= 4'h0;
            st_reg.host_rdata  <= 8'h00;
            st_reg.cpu_rdata   <= 8'h00;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----
    // alternate cpu reset pulse
    // ----
    // a write during a running sequence cannot restart it; the timer
    // ignores fire while busy
    kbm_alt_pulse u_alt_pulse
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .fire_i    (alt_fire & ~alt_busy),         // R15
        .rst_n_o   (alt_cpu_reset_n_o),
        .busy_o    (alt_busy)
    );

    // ----
    // interrupts
    // ----
    // without enable flags the port bits drive the irqs directly
    always_comb
    begin
        if (cpu_en_flags_i)
        begin
            kbd_host_irq_o = port_bit_irq_kbd_i & st_reg.output_buffer_full;          // R1 R18
            aux_host_irq_o = port_bit_irq_aux_i & ~st_reg.input_buffer_full;
        end
        else
        begin
            kbd_host_irq_o = port_bit_irq_kbd_i;
            aux_host_irq_o = port_bit_irq_aux_i;
        end
    end

    // cpu-side input full interrupt, cleared with the flag
    assign input_full_irq_n_o = ~(st_reg.input_buffer_full & cpu_ibf_irq_en_i);      // R7

    // ----
    // address-20 gate
    // ----
    assign alt_addr20_gate_o   = st_reg.alt_gate;                      // R14
    assign cpu_addr20_mask_n_o = port_bit_addr_gate_i | st_reg.alt_gate; // R19

    // ----
    // open-drain lines
    // ----
    // data is always low; the enable decides, so the pin only sinks
    assign kbd_clock_line_o    = 1'b0;
    assign kbd_data_line_o     = 1'b0;
    assign aux_clock_line_o    = 1'b0;
    assign aux_data_line_o     = 1'b0;
    assign kbd_clock_line_oe_o = st_reg.line_drive[`KBM_LN_KBD_CLOCK_LINE];      // R11
    assign kbd_data_line_oe_o  = st_reg.line_drive[`KBM_LN_KBD_DATA_LINE];      // R11
    assign aux_clock_line_oe_o = st_reg.line_drive[`KBM_LN_ACLK];      // R11
    assign aux_data_line_oe_o  = st_reg.line_drive[`KBM_LN_ADAT];      // R11

    // ----
    // read data and status outputs
    // ----
    assign host_rdata_o     = st_reg.host_rdata;
    assign cpu_rdata_o      = st_reg.cpu_rdata;
    assign cpu_cmd_flag_o   = st_reg.cmd_flag;
    assign cpu_line_state_o = st_reg.line_seen;

endmodule

`default_nettype wire

//--- kbm_map.svh
// keyboard host mailbox constants: ports, bits, resets and timing.
// assumes a 10 MHz controller clock; included by its bare name.
`ifndef KBM_MAP_SVH
`define KBM_MAP_SVH

// ----
// host i/o port addresses
// ----
`define KBM_ADDR_W          16
`define KBM_ADDR_DATA       16'h0060
`define KBM_ADDR_CMD        16'h0064
`define KBM_ADDR_FAST_GATE  16'h0092
`define KBM_ADDR_BIT_TWO    2

// ----
// host status byte layout
// ----
`define KBM_ST_OBF          0
`define KBM_ST_IBF          1
`define KBM_ST_CMD          3
`define KBM_ST_UD_MASK      8'hF4
`define KBM_ST_RESET        8'h00

// ----
// fast gate and reset register
// ----
`define KBM_FG_FIXED        8'h24
`define KBM_FG_RST_BIT      0
`define KBM_FG_GATE_BIT     1
`define KBM_CFG_FG_EN_BIT   2

// ----
// keyboard/aux line drive, one bit per line, 1 pulls low
// ----
`define KBM_LINE_RESET      4'hF
`define KBM_LN_KBD_CLOCK_LINE         0
`define KBM_LN_KBD_DATA_LINE         1
`define KBM_LN_ACLK         2
`define KBM_LN_ADAT         3

// ----
// timing
// ----
`define KBM_CLK_PERIOD_NS   100
`define KBM_ALT_DELAY_NS    500
`define KBM_ALT_PULSE_NS    1000
`define KBM_RST_HOLD_REF    24
`define KBM_CNT_W           8
`define KBM_ALT_DELAY_CYC   ((`KBM_ALT_DELAY_NS + `KBM_CLK_PERIOD_NS - 1) / `KBM_CLK_PERIOD_NS)
`define KBM_ALT_PULSE_CYC   ((`KBM_ALT_PULSE_NS + `KBM_CLK_PERIOD_NS - 1) / `KBM_CLK_PERIOD_NS)

`endif

//--- kbm_pkg.sv
// types shared by the keyboard host mailbox and its alternate reset timer.
// assumes kbm_map.svh supplies the widths.
`include "kbm_map.svh"

package kbm_pkg;

    // alternate reset sequencer states
    typedef enum logic [1:0] {
        KBM_PULSE_IDLE,
        KBM_PULSE_DELAY,
        KBM_PULSE_LOW
    } kbm_pulse_state_t;

    // state of the alternate reset timer
    typedef struct packed {
        kbm_pulse_state_t          state;
        logic [`KBM_CNT_W-1:0]     count;
        logic                      rst_n;
    } kbm_pulse_st_t;

    // state of the mailbox
    typedef struct packed {
        logic [7:0] out_buf;
        logic [7:0] in_buf;
        logic       output_buffer_full;
        logic       input_buffer_full;
        logic       cmd_flag;
        logic [7:0] user_bits;
        logic       alt_gate;
        logic       alt_rst_bit;
        logic [3:0] line_drive;
        logic [3:0] line_seen;
        logic [7:0] host_rdata;
        logic [7:0] cpu_rdata;
    } kbm_state_t;

endpackage

//--- kbm_alt_pulse.sv
// alternate cpu reset timer: waits a delay, then drives a low pulse.
// assumes fire_i is a one-cycle pulse on the controller clock.
`timescale 1ns/1ns
`default_nettype none
`include "kbm_map.svh"

module kbm_alt_pulse
(
    input  wire logic clk_i,      // controller clock
    input  wire logic sys_rst_i,  // async reset, active high
    input  wire logic fire_i,     // start one pulse
    output logic      rst_n_o,    // alternate reset, active low
    output logic      busy_o      // sequence in progress
);
    import kbm_pkg::*;

    localparam logic [`KBM_CNT_W-1:0] DELAY_CYC = `KBM_CNT_W'(`KBM_ALT_DELAY_CYC);
    localparam logic [`KBM_CNT_W-1:0] PULSE_CYC = `KBM_CNT_W'(`KBM_ALT_PULSE_CYC);
    localparam logic [`KBM_CNT_W-1:0] ONE       = `KBM_CNT_W'(1);

    kbm_pulse_st_t st_reg;
    kbm_pulse_st_t st_next;

    // ----
    // sequencer
    // ----
    // counts round up, so both minimum durations always hold
    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg.state)
            KBM_PULSE_IDLE:
            begin
                if (fire_i)
                begin
                    st_next.state = KBM_PULSE_DELAY; // R15
                    st_next.count = DELAY_CYC;       // R20
                end
            end
            KBM_PULSE_DELAY:
            begin
                if (st_reg.count == ONE)
                begin
                    st_next.state = KBM_PULSE_LOW;
                    st_next.count = PULSE_CYC;       // R20
                    st_next.rst_n = 1'b0;            // R15
                end
                else
                begin
                    st_next.count = st_reg.count - ONE;
                end
            end
            KBM_PULSE_LOW:
            begin
                if (st_reg.count == ONE)
                begin
                    st_next.state = KBM_PULSE_IDLE;
                    st_next.rst_n = 1'b1;
                end
                else
                begin
                    st_next.count = st_reg.count - ONE;
                end
            end
            default:
            begin
                st_next.state = KBM_PULSE_IDLE;
                st_next.rst_n = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_reg <= '{state: KBM_PULSE_IDLE, count: '0, rst_n: 1'b1};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rst_n_o = st_reg.rst_n;
    assign busy_o  = (st_reg.state != KBM_PULSE_IDLE);

endmodule

`default_nettype wire

//--- kbm_host_model.sv
// host-side bus model: single byte reads and writes at the i/o ports.
// assumes strobes are sampled on the rising edge of the controller clock.
`timescale 1ns/1ns
`default_nettype none
module kbm_host_model
(
    input  wire logic       clk_i,   // controller clock
    output logic [15:0]     addr_o,  // i/o address
    output logic            rd_o,    // read strobe
    output logic            wr_o,    // write strobe
    output logic [7:0]      wdata_o, // write data
    input  wire logic [7:0] rdata_i  // read data
);
    // idle bus parks on an address that nothing decodes
    initial
    begin
        addr_o = 16'h0000;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // strobe held to its sampling edge; released bus is inverted
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wr_o <= w;
        rd_o <= !w;
        wdata_o <= d;
        @(posedge clk_i);
        addr_o <= ~a;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        wdata_o <= ~d;
        #1;
        q = rdata_i;
    endtask
endmodule
`default_nettype wire

//--- kbm_mailbox_checker.sv
// port-level assertions for the keyboard host mailbox.
// assumes a bind to kbm_mailbox; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "kbm_map.svh"
module kbm_mailbox_checker
(
    input wire logic        clk_i,                // controller clock
    input wire logic        sys_rst_i,            // reset, active high
    input wire logic [15:0] host_addr_i,          // host address
    input wire logic        host_rd_i,            // host read
    input wire logic        host_wr_i,            // host write
    input wire logic [7:0]  host_wdata_i,         // host data
    input wire logic        host_claim_o,         // decode hit
    input wire logic [7:0]  kbd_reset_gate_cfg_i, // config byte
    input wire logic        kbd_host_irq_o,       // keyboard irq
    input wire logic        cpu_dbb_wr_i,         // cpu buffer write
    input wire logic        cpu_dbb_rd_i,         // cpu buffer read
    input wire logic        cpu_cmd_flag_o,       // command flag
    input wire logic        cpu_en_flags_i,       // flags mode
    input wire logic        cpu_ibf_irq_en_i,     // input irq enable
    input wire logic        input_full_irq_n_o,   // input irq
    input wire logic        port_bit_irq_kbd_i,   // irq port bit
    input wire logic        port_bit_addr_gate_i, // gate port bit
    input wire logic        alt_addr20_gate_o,    // alternate gate
    input wire logic        alt_cpu_reset_n_o,    // alternate reset
    input wire logic        cpu_addr20_mask_n_o   // mask output
);
    // decode of the three host ports
    wire hd = host_addr_i == `KBM_ADDR_DATA;
    wire hc = host_addr_i == `KBM_ADDR_CMD;
    wire hf = host_addr_i == `KBM_ADDR_FAST_GATE;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_OBF_IRQ: assert property (cpu_dbb_wr_i |=> kbd_host_irq_o == port_bit_irq_kbd_i)
        else $error("kbd irq after cpu write");
    AST_IBF_SET: assert property (host_wr_i && (hd || hc) |=> input_full_irq_n_o == !cpu_ibf_irq_en_i)
        else $error("ibf irq after host write");
    AST_IBF_CLR: assert property (cpu_dbb_rd_i && !(host_wr_i && (hd || hc)) |=> input_full_irq_n_o)
        else $error("ibf irq after cpu read");
    AST_CMD_FLAG: assert property (host_wr_i && (hd || hc) |=> cpu_cmd_flag_o == $past(hc))
        else $error("cmd flag wrong");
    AST_OBF_CLR: assert property (host_rd_i && hd && !cpu_dbb_wr_i |=> !kbd_host_irq_o || !cpu_en_flags_i)
        else $error("kbd irq after host read");
    AST_IRQ_GATE: assert property (!port_bit_irq_kbd_i |-> !kbd_host_irq_o)
        else $error("kbd irq not gated");
    AST_MASK_OR: assert property (cpu_addr20_mask_n_o == (port_bit_addr_gate_i | alt_addr20_gate_o))
        else $error("mask not or");
    AST_FG_CLAIM: assert property (hf |-> host_claim_o == kbd_reset_gate_cfg_i[2])
        else $error("gate claim wrong");
    AST_GATE_WR: assert property (host_wr_i && hf && kbd_reset_gate_cfg_i[2] |=> alt_addr20_gate_o == $past(host_wdata_i[1]))
        else $error("alt gate wrong");
    AST_PULSE_W: assert property ($fell(alt_cpu_reset_n_o) |-> (!alt_cpu_reset_n_o)[*8] ##1 !alt_cpu_reset_n_o ##1 !alt_cpu_reset_n_o ##1 alt_cpu_reset_n_o)
        else $error("alt pulse width");
endmodule
bind kbm_mailbox kbm_mailbox_checker chk_u (.*);
`default_nettype wire

//--- kbd_host_mailbox_port92_test.sv
// self-checking bench for the host mailbox against a queue model.
// assumes the host model drives the host port; lines have pull-ups.
`timescale 1ns/1ns
`default_nettype none
`include "kbm_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %0h %0h", $time, (a), (b)); end end
module kbd_host_mailbox_port92_test;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, cpu_en_flags_i = 1'b1, cpu_ibf_irq_en_i = 1'b0;
    logic port_bit_irq_kbd_i = 1'b1, port_bit_irq_aux_i = 1'b0, port_bit_addr_gate_i = 1'b0;
    logic [7:0] kbd_reset_gate_cfg_i = 8'h04, cpu_wdata_i = 8'h00, q, m_ud = 8'h00, mq[$];
    logic [3:0] cs = 4'h0, cpu_line_drive_i = 4'h0;
    logic [31:0] r = 32'h1668;
    int n_mismatch = 0, comparisons = 0, cyc = 0, k;
    int pv[4] = '{1, 1, 0, 1};
    wire cpu_dbb_wr_i = cs[3], cpu_dbb_rd_i = cs[2], cpu_sts_wr_i = cs[1], cpu_sts_rd_i = cs[0];
    wire [15:0] host_addr_i;
    wire host_rd_i, host_wr_i, host_claim_o, kbd_host_irq_o, aux_host_irq_o, cpu_cmd_flag_o;
    wire [7:0] host_wdata_i, host_rdata_o, cpu_rdata_o;
    wire input_full_irq_n_o, kbd_clock_line_o, kbd_data_line_o, aux_clock_line_o, aux_data_line_o;
    wire alt_addr20_gate_o, alt_cpu_reset_n_o, cpu_addr20_mask_n_o;
    wire kbd_clock_line_oe_o, kbd_data_line_oe_o, aux_clock_line_oe_o, aux_data_line_oe_o;
    wire [3:0] cpu_line_state_o;
    // released open-drain lines are pulled high
    wire kbd_clock_line_i = !kbd_clock_line_oe_o, kbd_data_line_i = !kbd_data_line_oe_o;
    wire aux_clock_line_i = !aux_clock_line_oe_o, aux_data_line_i = !aux_data_line_oe_o;
    wire [3:0] oe = {aux_data_line_oe_o, aux_clock_line_oe_o, kbd_data_line_oe_o, kbd_clock_line_oe_o};
    kbm_mailbox dut_u (.*);
    kbm_host_model host_u (.clk_i(clk_i), .addr_o(host_addr_i), .rd_o(host_rd_i), .wr_o(host_wr_i),
                           .wdata_o(host_wdata_i), .rdata_i(host_rdata_o));
    // 10 MHz controller clock
    always #50 clk_i = ~clk_i;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one cpu strobe, {dbb_wr, dbb_rd, sts_wr, sts_rd}
    task automatic cop(input logic [3:0] s, input logic [7:0] d);
        @(posedge clk_i);
        cs <= s;
        cpu_wdata_i <= d;
        @(posedge clk_i);
        cs <= 4'h0;
        #1;
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog: the run needs under a thousand cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            complete_run();
        end
    end
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        `CHK(oe, `KBM_LINE_RESET)
        sys_rst_i <= 1'b0;
        host_u.xfer(1'b0, `KBM_ADDR_CMD, 8'h00, q);
        `CHK(q, `KBM_ST_RESET)
        host_u.xfer(1'b0, `KBM_ADDR_FAST_GATE, 8'h00, q);
        `CHK(q, `KBM_FG_FIXED)
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            r = nx(r);
            cpu_line_drive_i <= r[3:0];
            cpu_ibf_irq_en_i <= r[4];
            port_bit_irq_aux_i <= r[5];
            port_bit_addr_gate_i <= r[6];
            cop(4'h8, r[15:8]);
            `CHK(kbd_host_irq_o, 1'b1)
            host_u.xfer(1'b0, `KBM_ADDR_DATA, 8'h00, q);
            `CHK(q, r[15:8])
            `CHK(kbd_host_irq_o, 1'b0)
            host_u.xfer(1'b1, r[7] ? `KBM_ADDR_CMD : `KBM_ADDR_DATA, r[23:16], q);
            mq.push_back(r[23:16]);
            `CHK(input_full_irq_n_o, !r[4])
            `CHK(cpu_cmd_flag_o, r[7])
            cop(4'h2, r[31:24]);
            m_ud = r[31:24] & `KBM_ST_UD_MASK;
            host_u.xfer(1'b0, `KBM_ADDR_CMD, 8'h00, q);
            `CHK(q, {m_ud[7:4], r[7], m_ud[2], 2'b10})
            cop(4'h4, 8'h00);
            `CHK(cpu_rdata_o, mq.pop_front())
            `CHK(input_full_irq_n_o, 1'b1)
            `CHK(aux_host_irq_o, r[5])
            cop(4'h1, 8'h00);
            `CHK(cpu_rdata_o, {m_ud[7:4], r[7], m_ud[2], 2'b00})
            `CHK(oe, r[3:0])
            `CHK(cpu_line_state_o, ~r[3:0])
        end
        @(posedge clk_i);
        cpu_en_flags_i <= 1'b0;
        @(posedge clk_i);
        #1;
        `CHK(kbd_host_irq_o, 1'b1)
        @(posedge clk_i);
        port_bit_irq_kbd_i <= 1'b0;
        kbd_reset_gate_cfg_i <= 8'h00;
        host_u.xfer(1'b1, `KBM_ADDR_FAST_GATE, 8'h03, q);
        `CHK(alt_addr20_gate_o, 1'b0)
        `CHK(kbd_host_irq_o, 1'b0)
        kbd_reset_gate_cfg_i <= 8'h04;
        host_u.xfer(1'b1, `KBM_ADDR_FAST_GATE, 8'hFE, q);
        `CHK(alt_addr20_gate_o, 1'b1)
        host_u.xfer(1'b0, `KBM_ADDR_FAST_GATE, 8'h00, q);
        `CHK(q, 8'h26)
        // bit 0 written 1, 1, 0, 1: only a rising write starts a pulse
        foreach (pv[j])
        begin
            host_u.xfer(1'b1, `KBM_ADDR_FAST_GATE, pv[j][7:0], q);
            for (k = 0; alt_cpu_reset_n_o && k < 30; k++)
                @(posedge clk_i) #1;
            `CHK(k, j == 0 || j == 3 ? `KBM_ALT_DELAY_CYC : 30)
            for (k = 0; !alt_cpu_reset_n_o && k < 30; k++)
                @(posedge clk_i) #1;
            `CHK(k, j == 0 || j == 3 ? `KBM_ALT_PULSE_CYC : 0)
        end
        host_u.xfer(1'b0, `KBM_ADDR_FAST_GATE, 8'h00, q);
        `CHK(q, 8'h25)
        complete_run();
    end
endmodule
`default_nettype wire
